// [hdl/vif_forwarder.sv]
// indirect vco packet forwarder with band calibration sequencer
// Overview of operation
// - internal link packets are sixteen bits
// - link clock from calibration clock, max 50 MHz
// - two-bit field selects link clock rate
// - each packet write is forwarded MSB first
// - receiver accepts only target select zero
// - bits 6:3 select remote register
// - bits 15:7 are nine-bit payload
// - payload six to register two divides by two
// - calibration writes to stored select and index
// - nonzero target select disables calibration
// - calibration needs low seven bits zero
// - final divider write triggers calibration
// - skipped clearing procedure means no lock
// - divider write after zero packet relocks
// - two cores with 128 subbands each
// - relock option reruns calibration once
// - calibration bit routes reference to tuning
// - vco registers write-only, band readable
// - calibration runs on each final divider write unless the disable bit is set or packet bits 6:0 are nonzero
`timescale 1ns/1ps
module vif_forwarder import vif_pkg::*; (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic HOST_WE,
   input wire logic [4:0] HOST_ADDR,
   input wire logic [15:0] HOST_WDATA,
   input wire logic FRAC_MODE,
   input wire logic REF_CLK_IN,
   input wire logic LOCK_DETECT,
   input wire logic FREQ_HIGH,
   output logic LINK_CLK,
   output logic LINK_DATA,
   output logic LINK_LATCH,
   output logic BUSY,
   output logic CAL_ACTIVE,
   output logic CAL_FAULT,
   output logic [7:0] BAND_READBACK,
   output logic VT_FROM_REF,
   output logic [8:0] VCO_DIV_CTRL,
   output logic VCO_DIV_TWO
);
   vif_state_t st_reg, st_next;
   logic ref_edge;
   logic lock_fall;
   logic tick;
   logic host_trig;
   logic relock_trig;

   // sync stage 0 feeds only stage 1; edges compare stages 1 and 2
   assign ref_edge = st_reg.ref_sync[1] && !st_reg.ref_sync[2];
   assign lock_fall = !st_reg.lock_sync[1] && st_reg.lock_sync[2];

   // the mode input decides which divider write is the final one
   assign host_trig = HOST_WE && !st_reg.cal_ctrl_reg[CAL_DIS_BIT] &&
      ((HOST_ADDR == ADDR_INT_DIV && !FRAC_MODE) ||
       (HOST_ADDR == ADDR_FRAC_DIV && FRAC_MODE));
   assign relock_trig = lock_fall && st_reg.relock_en_reg && !st_reg.retried &&
      st_reg.cal == CAL_IDLE;

   always_comb begin
      logic [5:0] lim;
      logic [7:0] nb;
      lim = div_limit(st_reg.cal_ctrl_reg[CLKSEL_MSB:CLKSEL_LSB]);
      nb = st_reg.band;
      tick = 1'b0;
      st_next = st_reg;
      st_next.ref_sync = {st_reg.ref_sync[1:0], REF_CLK_IN};
      st_next.lock_sync = {st_reg.lock_sync[1:0], LOCK_DETECT};
      st_next.fhi_sync = {st_reg.fhi_sync[0], FREQ_HIGH};

      // link half-period tick: divided reference, never faster than the link limit
      if (ref_edge) begin
         if (st_reg.div_cnt < lim) begin
            st_next.div_cnt = st_reg.div_cnt + 6'h01;
         end else if (st_reg.gap_cnt >= GAP_MIN) begin
            tick = 1'b1;
            st_next.div_cnt = 6'h00;
         end
      end
      if (tick) begin
         st_next.gap_cnt = 3'h0;
      end else if (st_reg.gap_cnt != 3'h7) begin
         st_next.gap_cnt = st_reg.gap_cnt + 3'h1;
      end

      // serializer; calibration traffic goes ahead of a waiting host packet
      if (tick) begin
         unique case (st_reg.ser)
            SER_IDLE: begin
               if (st_reg.cal_req) begin
                  st_next.shift = st_reg.cal_pkt;
                  st_next.cal_req = 1'b0;
                  st_next.bit_cnt = LAST_BIT;
                  st_next.ser = SER_LOW;
               end else if (st_reg.host_pend) begin
                  st_next.shift = st_reg.pkt_reg;
                  st_next.host_pend = 1'b0;
                  st_next.bit_cnt = LAST_BIT;
                  st_next.ser = SER_LOW;
               end
            end
            SER_LOW: begin
               st_next.lk_clk = 1'b0;
               st_next.lk_dat = st_reg.shift[PKT_BITS-1];
               st_next.ser = SER_HIGH;
            end
            SER_HIGH: begin
               st_next.lk_clk = 1'b1;
               st_next.shift = {st_reg.shift[14:0], 1'b0};
               if (st_reg.bit_cnt == 4'h0) begin
                  st_next.ser = SER_LATCH;
               end else begin
                  st_next.bit_cnt = st_reg.bit_cnt - 4'h1;
                  st_next.ser = SER_LOW;
               end
            end
            SER_LATCH: begin
               st_next.lk_clk = 1'b0;
               st_next.lk_le = 1'b1;
               st_next.ser = SER_END;
            end
            SER_END: begin
               st_next.lk_le = 1'b0;
               st_next.ser = SER_IDLE;
            end
            default: begin
               st_next.ser = SER_IDLE;
            end
         endcase
      end

      // band search: one packet per trial bit, then close with the cal bit low
      unique case (st_reg.cal)
         CAL_IDLE: begin
         end
         CAL_SEND: begin
            if (!st_reg.cal_req && st_reg.ser == SER_IDLE) begin
               st_next.settle = 3'h0;
               st_next.cal = CAL_WAIT;
            end
         end
         CAL_WAIT: begin
            if (tick) begin
               st_next.settle = st_reg.settle + 3'h1;
               if (st_reg.settle == SETTLE_LAST) begin
                  if (st_reg.fhi_sync[1]) begin
                     nb[st_reg.bit_pos] = 1'b0;
                  end
                  if (st_reg.bit_pos == 3'h0) begin
                     st_next.cal_pkt = make_pkt(nb, 1'b0, st_reg.pkt_reg[6:0]);
                     st_next.cal = CAL_CLOSE;
                  end else begin
                     nb[st_reg.bit_pos - 3'h1] = 1'b1;
                     st_next.bit_pos = st_reg.bit_pos - 3'h1;
                     st_next.cal_pkt = make_pkt(nb, 1'b1, st_reg.pkt_reg[6:0]);
                     st_next.cal = CAL_SEND;
                  end
                  st_next.band = nb;
                  st_next.cal_req = 1'b1;
               end
            end
         end
         CAL_CLOSE: begin
            if (!st_reg.cal_req && st_reg.ser == SER_IDLE) begin
               st_next.cal = CAL_IDLE;
            end
         end
      endcase

      // host register writes; a write in the take cycle still leaves a pending packet
      if (HOST_WE) begin
         unique case (HOST_ADDR)
            ADDR_VCO_PKT: begin
               st_next.pkt_reg = HOST_WDATA;
               st_next.host_pend = 1'b1;
            end
            ADDR_CAL_CTRL: st_next.cal_ctrl_reg = HOST_WDATA;
            ADDR_LOCK_CFG: st_next.relock_en_reg = HOST_WDATA[RELOCK_BIT];
            default: begin
            end
         endcase
      end

      // a fresh request re-arms the single relock try
      if (host_trig || relock_trig) begin
         st_next.retried = !host_trig;
         if (st_reg.pkt_reg[IDX_MSB:ID_LSB] == 7'h00) begin
            st_next.fault = 1'b0;
            st_next.band = BAND_START;
            st_next.bit_pos = BAND_TOP_BIT;
            st_next.cal_pkt = make_pkt(BAND_START, 1'b1, st_reg.pkt_reg[6:0]);
            st_next.cal_req = 1'b1;
            st_next.cal = CAL_SEND;
         end else begin
            // no calibration, so the loop cannot lock on the new frequency
            st_next.fault = 1'b1;
            st_next.cal_req = 1'b0;
            st_next.cal = CAL_IDLE;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg <= '0;
         st_reg.pkt_reg <= PKT_RST;
         st_reg.cal_ctrl_reg <= CAL_CTRL_RST;
         st_reg.ser <= SER_IDLE;
         st_reg.cal <= CAL_IDLE;
      end else if (CE) begin
         st_reg <= st_next;
      end
   end

   vif_vco_rx u_rx (
      .clk(CLOCK),
      .rst_n(RST_N),
      .ce(CE),
      .lk_clk(st_reg.lk_clk),
      .lk_dat(st_reg.lk_dat),
      .lk_le(st_reg.lk_le),
      .band_rb(BAND_READBACK),
      .vt_from_ref(VT_FROM_REF),
      .div_ctrl(VCO_DIV_CTRL),
      .div_by_two(VCO_DIV_TWO)
   );

   assign LINK_CLK = st_reg.lk_clk;
   assign LINK_DATA = st_reg.lk_dat;
   assign LINK_LATCH = st_reg.lk_le;
   assign BUSY = st_reg.ser != SER_IDLE || st_reg.host_pend || st_reg.cal_req;
   assign CAL_ACTIVE = st_reg.cal != CAL_IDLE;
   assign CAL_FAULT = st_reg.fault;

   // helper counters for the checks below
   logic [4:0] rises_reg;
   logic [3:0] since_rise_reg;
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rises_reg <= 5'h00;
         since_rise_reg <= 4'h0;
      end else if (CE) begin
         if (st_reg.lk_le) begin
            rises_reg <= 5'h00;
         end else if (st_next.lk_clk && !st_reg.lk_clk) begin
            rises_reg <= rises_reg + 5'h01;
         end
         if (st_next.lk_clk && !st_reg.lk_clk) begin
            since_rise_reg <= 4'h0;
         end else if (since_rise_reg != 4'hF) begin
            since_rise_reg <= since_rise_reg + 4'h1;
         end
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   property p_sixteen_bits;
      $rose(st_reg.lk_le) |-> rises_reg == 5'd16;
   endproperty
   a_sixteen_bits: assert property (p_sixteen_bits) else $error("frame not 16 bits");

   property p_link_rate;
      (CE && st_next.lk_clk && !st_reg.lk_clk) |-> since_rise_reg >= 4'd2;
   endproperty
   a_link_rate: assert property (p_link_rate) else $error("link clock too fast");

   property p_msb_first;
      (CE && st_reg.ser == SER_LOW && tick) |=> st_reg.lk_dat == $past(st_reg.shift[15]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("bit order wrong");

   property p_one_frame;
      $fell(st_reg.host_pend) |-> $past(st_reg.ser) == SER_IDLE && st_reg.ser == SER_LOW;
   endproperty
   a_one_frame: assert property (p_one_frame) else $error("packet taken mid frame");

   property p_bad_target;
      (CE && host_trig && st_reg.pkt_reg[2:0] != 3'h0)
         |=> CAL_FAULT && !CAL_ACTIVE && !st_reg.cal_req;
   endproperty
   a_bad_target: assert property (p_bad_target) else $error("calibrated with bad target");

   property p_auto_cal;
      (CE && host_trig && st_reg.pkt_reg[6:0] == 7'h00)
         |=> st_reg.cal == CAL_SEND && st_reg.cal_req && !CAL_FAULT;
   endproperty
   a_auto_cal: assert property (p_auto_cal) else $error("calibration not started");

   property p_cal_addr;
      $rose(st_reg.cal_req) |-> st_reg.cal_pkt[6:0] == st_reg.pkt_reg[6:0];
   endproperty
   a_cal_addr: assert property (p_cal_addr) else $error("calibration address wrong");

   property p_relock_once;
      (CE && st_reg.retried && lock_fall && !host_trig && st_reg.cal == CAL_IDLE)
         |=> st_reg.cal == CAL_IDLE;
   endproperty
   a_relock_once: assert property (p_relock_once) else $error("relock retried twice");

   sequence s_close_go;
      st_reg.cal == CAL_CLOSE && !st_reg.cal_req && st_reg.ser == SER_IDLE && CE;
   endsequence
   sequence s_idle_open;
      st_reg.cal == CAL_IDLE && !VT_FROM_REF;
   endsequence
   property p_close_ends;
      s_close_go |=> s_idle_open;
   endproperty
   a_close_ends: assert property (p_close_ends) else $error("calibration did not end");
endmodule : vif_forwarder

// [hdl/vif_pkg.sv]
// package: constants, types and helpers for the indirect vco packet forwarder
package vif_pkg;
   // host-side register map (word index on the host register port)
   localparam logic [4:0] ADDR_INT_DIV = 5'h03;
   localparam logic [4:0] ADDR_FRAC_DIV = 5'h04;
   localparam logic [4:0] ADDR_VCO_PKT = 5'h05;
   localparam logic [4:0] ADDR_LOCK_CFG = 5'h07;
   localparam logic [4:0] ADDR_CAL_CTRL = 5'h0A;
   localparam logic [4:0] ADDR_BAND_RB = 5'h10;
   // field positions
   localparam int CLKSEL_LSB = 13;
   localparam int CLKSEL_MSB = 14;
   localparam int CAL_DIS_BIT = 11;
   localparam int RELOCK_BIT = 13;
   localparam int ID_LSB = 0;
   localparam int ID_MSB = 2;
   localparam int IDX_LSB = 3;
   localparam int IDX_MSB = 6;
   localparam int PAY_LSB = 7;
   localparam int PAY_MSB = 15;
   localparam int PKT_BITS = 16;
   localparam logic [2:0] ID_SELF = 3'h0;
   localparam logic [3:0] IDX_BAND = 4'h0;
   localparam logic [3:0] IDX_OUTDIV = 4'h2;
   localparam logic [8:0] PAY_DIV_TWO = 9'h006;
   // reset values
   localparam logic [15:0] PKT_RST = 16'h0000;
   localparam logic [15:0] CAL_CTRL_RST = 16'h4000;
   localparam logic [8:0] VREG_RST = 9'h000;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int LINK_MAX_MHZ = 50;
   localparam int LINK_MIN_PERIOD_NS = 1000 / LINK_MAX_MHZ;
   localparam int HALF_GAP_CYC = (LINK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] GAP_MIN = 3'(HALF_GAP_CYC - 1);
   localparam logic [2:0] SETTLE_LAST = 3'h3;
   localparam logic [3:0] LAST_BIT = 4'hF;
   localparam logic [7:0] BAND_START = 8'h80;
   localparam logic [2:0] BAND_TOP_BIT = 3'h7;

   typedef enum logic [2:0] {
      SER_IDLE = 3'b000,
      SER_LOW = 3'b001,
      SER_HIGH = 3'b010,
      SER_LATCH = 3'b011,
      SER_END = 3'b100
   } vif_ser_t;

   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_SEND = 2'b01,
      CAL_WAIT = 2'b10,
      CAL_CLOSE = 2'b11
   } vif_cal_t;

   typedef struct packed {
      logic [2:0] ref_sync;
      logic [2:0] lock_sync;
      logic [1:0] fhi_sync;
      logic [5:0] div_cnt;
      logic [2:0] gap_cnt;
      logic [15:0] pkt_reg;
      logic [15:0] cal_ctrl_reg;
      logic relock_en_reg;
      logic host_pend;
      logic cal_req;
      logic [15:0] cal_pkt;
      vif_ser_t ser;
      logic [15:0] shift;
      logic [3:0] bit_cnt;
      logic lk_clk;
      logic lk_dat;
      logic lk_le;
      vif_cal_t cal;
      logic [7:0] band;
      logic [2:0] bit_pos;
      logic [2:0] settle;
      logic retried;
      logic fault;
   } vif_state_t;

   typedef struct packed {
      logic [15:0] shift;
      logic clk_prev;
      logic le_prev;
      logic [15:0][8:0] vreg;
   } vif_rx_t;

   // reference edges per link half-period, minus one: 0, 3, 15, 31
   function automatic logic [5:0] div_limit(input logic [1:0] sel);
      unique case (sel)
         2'b00: div_limit = 6'h00;
         2'b01: div_limit = 6'h03;
         2'b10: div_limit = 6'h0F;
         2'b11: div_limit = 6'h1F;
      endcase
   endfunction : div_limit

   // band packet: payload is band plus calibration bit, address bits reused
   function automatic logic [15:0] make_pkt(input logic [7:0] band, input logic cal,
                                            input logic [6:0] addr);
      make_pkt = {band, cal, addr};
   endfunction : make_pkt
endpackage : vif_pkg

// [hdl/vif_vco_rx.sv]
// vco subsystem end of the internal serial link: packet decode and register bank
`timescale 1ns/1ps
module vif_vco_rx import vif_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic lk_clk,
   input wire logic lk_dat,
   input wire logic lk_le,
   output logic [7:0] band_rb,
   output logic vt_from_ref,
   output logic [8:0] div_ctrl,
   output logic div_by_two
);
   vif_rx_t st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      st_next.clk_prev = lk_clk;
      st_next.le_prev = lk_le;
      if (lk_clk && !st_reg.clk_prev) begin
         st_next.shift = {st_reg.shift[14:0], lk_dat};
      end
      // only target zero accepts; index picks one of sixteen write-only regs
      if (lk_le && !st_reg.le_prev && st_reg.shift[ID_MSB:ID_LSB] == ID_SELF) begin
         st_next.vreg[st_reg.shift[IDX_MSB:IDX_LSB]] = st_reg.shift[PAY_MSB:PAY_LSB];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // core in bit 7, subband in bits 6:0
   assign band_rb = st_reg.vreg[IDX_BAND][8:1];
   assign vt_from_ref = st_reg.vreg[IDX_BAND][0];
   assign div_ctrl = st_reg.vreg[IDX_OUTDIV];
   assign div_by_two = (st_reg.vreg[IDX_OUTDIV] == PAY_DIV_TWO);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_foreign_ignored;
      (ce && lk_le && !st_reg.le_prev && st_reg.shift[ID_MSB:ID_LSB] != ID_SELF)
         |=> $stable(st_reg.vreg);
   endproperty
   a_foreign_ignored: assert property (p_foreign_ignored) else $error("foreign packet written");

   property p_div_two;
      (ce && lk_le && !st_reg.le_prev && st_reg.shift == 16'h0310) |=> div_by_two;
   endproperty
   a_div_two: assert property (p_div_two) else $error("divide by two not set");
endmodule : vif_vco_rx

// [sim/vif_host_model.sv]
// host controller model driving the register write port
`timescale 1ns/1ps
module vif_host_model import vif_pkg::*; (
   input wire logic clk,
   input wire logic [7:0] band_rb,
   output logic we,
   output logic [4:0] addr,
   output logic [15:0] wdata,
   output logic frac_mode
);
   initial begin
      we = 1'b0;
      addr = 5'h1F;
      wdata = 16'hFFFF;
      frac_mode = 1'b0;
   end

   // one-cycle strobe; a second call always leaves one idle edge between writes
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
      // released lines flip so a stale value never looks like a request
      addr <= ~a;
      wdata <= ~d;
   endtask : wr

   // mode level changes only on a clock edge
   task automatic set_frac(input logic m);
      @(posedge clk);
      frac_mode <= m;
   endtask : set_frac

   // band rewrite built from the readback, with band bit 5 forced to one
   function automatic logic [15:0] keep_pkt();
      return {band_rb[7:6], 1'b1, band_rb[4:0], 8'h00};
   endfunction : keep_pkt
endmodule : vif_host_model

// [sim/vif_forwarder_tb.sv]
// self-checking bench for the indirect vco packet forwarder
`timescale 1ns/1ps
module vif_forwarder_tb import vif_pkg::*;;
   typedef struct packed {
      logic [15:0] d;
      logic [8:0] ctrl;
      logic two;
      logic [7:0] band;
      logic vt;
   } vif_row_t;
   // bit 5 set so the keep-band rewrite cannot alter the band
   localparam logic [7:0] TARGET = 8'hA5;
   logic clock = 1'b0;
   logic rst_n, ref_clk, lock, freq_high;
   logic we, frac, lk_clk, lk_dat, lk_le, busy, cal_act, cal_fault, vt, two;
   logic [4:0] addr;
   logic [15:0] wdata;
   logic [7:0] band;
   logic [8:0] ctrl;
   logic lk_d = 1'b0;
   logic le_d = 1'b0;
   logic vt_seen = 1'b0;
   logic [15:0] sh = 16'h0000;
   logic [15:0] cap[$];
   int nb = 0;
   int n_cap = 0;
   logic ce = 1'b1;
   int hcnt = 0;
   int hi_len = 0;
   int n_fail = 0;
   int n_compared = 0;
   int lims[4] = '{1, 4, 16, 32};
   vif_row_t rows[5] = '{
      '{16'h0310, 9'h006, 1'b1, 8'h00, 1'b0},
      '{16'h0311, 9'h006, 1'b1, 8'h00, 1'b0},
      '{16'h0210, 9'h004, 1'b0, 8'h00, 1'b0},
      '{16'hFF90, 9'h1FF, 1'b0, 8'h00, 1'b0},
      '{16'h5A80, 9'h1FF, 1'b0, 8'h5A, 1'b1}};

   initial begin
      forever #4 clock = ~clock;
   end
   // reference offset from the system clock to keep edge sampling race free
   initial begin
      ref_clk = 1'b0;
      #2;
      forever #32 ref_clk = ~ref_clk;
   end
   // vco runs high while the trial band sits above the one that fits
   assign freq_high = band > TARGET;

   vif_host_model host (.clk(clock), .band_rb(band), .we(we), .addr(addr), .wdata(wdata),
      .frac_mode(frac));
   vif_forwarder dut (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .HOST_WE(we),
      .HOST_ADDR(addr), .HOST_WDATA(wdata), .FRAC_MODE(frac), .REF_CLK_IN(ref_clk),
      .LOCK_DETECT(lock), .FREQ_HIGH(freq_high), .LINK_CLK(lk_clk), .LINK_DATA(lk_dat),
      .LINK_LATCH(lk_le), .BUSY(busy), .CAL_ACTIVE(cal_act), .CAL_FAULT(cal_fault),
      .BAND_READBACK(band), .VT_FROM_REF(vt), .VCO_DIV_CTRL(ctrl), .VCO_DIV_TWO(two));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // link receiver: shifts on link clock rise, frames on latch rise
   always @(posedge clock) begin
      lk_d <= lk_clk;
      le_d <= lk_le;
      if (cal_act && vt) vt_seen <= 1'b1;
      if (lk_clk) hcnt <= hcnt + 1;
      else if (lk_d) begin
         hi_len <= hcnt;
         hcnt <= 0;
      end
      if (lk_clk && !lk_d) begin
         sh <= {sh[14:0], lk_dat};
         nb <= nb + 1;
      end
      if (lk_le && !le_d) begin
         cap.push_back(sh);
         chk(16'(nb), 16'h0010);
         nb <= 0;
      end
      // a frame cut by reset must not leave a partial bit count
      if (!rst_n) nb <= 0;
   end

   task automatic wait_idle();
      int i;
      repeat (3) @(posedge clock);
      for (i = 0; i < 20000 && (busy || cal_act); i++) @(posedge clock);
      chk({14'h0000, busy, cal_act}, 16'h0000);
      @(posedge clock);
   endtask : wait_idle

   // divider write, then look at the calibration flags one cycle on
   task automatic trig(input logic [4:0] a, input logic act, input logic flt);
      host.wr(a, 16'h0040);
      @(posedge clock);
      #1;
      chk({14'h0000, cal_act, cal_fault}, {14'h0000, act, flt});
   endtask : trig

   task automatic watch(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (50) begin
         @(posedge clock);
         seen = seen | cal_act;
      end
      chk({15'h0000, seen}, {15'h0000, exp});
   endtask : watch

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      #800000;
      n_fail++;
      print_verdict();
   end

   initial begin
      rst_n = 1'b0;
      lock = 1'b1;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      chk({lk_clk, lk_dat, lk_le, busy, cal_act, cal_fault, vt, two, band}, 16'h0000);
      chk({7'h00, ctrl}, 16'h0000);
      // slowest rate first, ending on the fastest for the long sequences
      for (int s = 3; s >= 0; s--) begin
         host.wr(ADDR_CAL_CTRL, 16'(s) << CLKSEL_LSB);
         host.wr(ADDR_VCO_PKT, 16'h0310);
         wait_idle();
         chk(16'(hi_len), 16'(lims[s] * 8));
         chk(cap[$], 16'h0310);
      end
      foreach (rows[i]) begin
         host.wr(ADDR_VCO_PKT, rows[i].d);
         wait_idle();
         chk(cap[$], rows[i].d);
         chk({7'h00, ctrl}, {7'h00, rows[i].ctrl});
         chk({15'h0000, two}, {15'h0000, rows[i].two});
         chk({7'h00, vt, band}, {7'h00, rows[i].vt, rows[i].band});
      end
      // second write lands while the first frame is shifting
      host.wr(ADDR_VCO_PKT, 16'h1234);
      repeat (40) @(posedge clock);
      host.wr(ADDR_VCO_PKT, 16'h0310);
      wait_idle();
      chk(cap[$-1], 16'h1234);
      chk(cap[$], 16'h0310);
      host.wr(ADDR_VCO_PKT, 16'h0003);
      wait_idle();
      trig(ADDR_INT_DIV, 1'b0, 1'b1);
      host.wr(ADDR_VCO_PKT, 16'h0008);
      wait_idle();
      trig(ADDR_INT_DIV, 1'b0, 1'b1);
      host.wr(ADDR_VCO_PKT, 16'h0000);
      wait_idle();
      chk({8'h00, band}, 16'h0000);
      trig(ADDR_INT_DIV, 1'b1, 1'b0);
      wait_idle();
      chk({6'h00, vt, vt_seen, band}, {8'h01, TARGET});
      host.wr(ADDR_VCO_PKT, host.keep_pkt());
      wait_idle();
      chk({8'h00, band}, {8'h00, TARGET});
      host.set_frac(1'b1);
      trig(ADDR_INT_DIV, 1'b0, 1'b0);
      trig(ADDR_FRAC_DIV, 1'b1, 1'b0);
      wait_idle();
      chk({8'h00, band}, {8'h00, TARGET});
      host.wr(ADDR_CAL_CTRL, 16'h0800);
      trig(ADDR_FRAC_DIV, 1'b0, 1'b0);
      host.wr(ADDR_CAL_CTRL, 16'h0000);
      host.wr(ADDR_LOCK_CFG, 16'h2000);
      trig(ADDR_FRAC_DIV, 1'b1, 1'b0);
      wait_idle();
      lock <= 1'b0;
      watch(1'b1);
      lock <= 1'b1;
      wait_idle();
      lock <= 1'b0;
      watch(1'b0);
      lock <= 1'b1;
      // frozen clock enable holds a frame mid flight
      host.wr(ADDR_VCO_PKT, 16'h0210);
      repeat (40) @(posedge clock);
      ce <= 1'b0;
      n_cap = cap.size();
      repeat (300) @(posedge clock);
      chk({15'h0000, busy}, 16'h0001);
      chk(16'(cap.size()), 16'(n_cap));
      ce <= 1'b1;
      wait_idle();
      chk(cap[$], 16'h0210);
      chk({7'h00, ctrl}, 16'h0004);
      // reset in mid frame, then the link rate after reset
      host.wr(ADDR_VCO_PKT, 16'h0310);
      repeat (40) @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk({lk_clk, lk_dat, lk_le, busy, cal_act, cal_fault, vt, two, band}, 16'h0000);
      chk({7'h00, ctrl}, 16'h0000);
      @(posedge clock);
      rst_n <= 1'b1;
      host.wr(ADDR_VCO_PKT, 16'h0310);
      wait_idle();
      chk(16'(hi_len), 16'(lims[2] * 8));
      chk(cap[$], 16'h0310);
      chk({15'h0000, two}, 16'h0001);
      print_verdict();
   end
endmodule : vif_forwarder_tb
